// *** verilog/cpu_regs_pkg.sv ***
// Package: register map, command layout, flag positions and reset values of the register set.
`default_nettype none
package cpu_regs_pkg;
	// Byte addresses on the register bus; each register takes one aligned word.
	localparam logic [7:0]  GEN_BASE  = 8'h00;
	localparam logic [7:0]  SEG_BASE  = 8'h20;
	localparam logic [7:0]  IP_ADDR   = 8'h30;
	localparam logic [7:0]  PSW_ADDR  = 8'h34;
	localparam logic [7:0]  CMD_ADDR  = 8'h38;
	localparam logic [7:0]  MEM_ADDR  = 8'h3c;
	localparam logic [7:0]  PHYS_ADDR = 8'h40;

	localparam int CARRY_POS  = 0;
	localparam int PARITY_POS = 2;
	localparam int AUX_POS    = 4;
	localparam int ZERO_POS   = 6;
	localparam int SIGN_POS   = 7;
	localparam int STEP_POS   = 8;
	localparam int INTR_POS   = 9;
	localparam int DIR_POS    = 10;
	localparam int OVFL_POS   = 11;

	localparam logic [15:0] PSW_RESET    = 16'h0000;
	localparam logic [15:0] PSW_LIVE     = 16'h0fd5;
	localparam logic [15:0] PSW_RSVD_VAL = 16'h0000;
	localparam logic [15:0] GEN_RESET    = 16'h0000;
	localparam logic [15:0] SEG_RESET    = 16'h0000;
	localparam logic [15:0] IP_RESET     = 16'h0000;
	localparam logic [15:0] BYTE_STEP    = 16'h0001;
	localparam logic [15:0] WORD_STEP    = 16'h0002;
	localparam int          SEG_SHIFT    = 4;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	typedef enum logic [3:0] {
		OP_ADD  = 4'h0, OP_ADC = 4'h1, OP_SUB = 4'h2, OP_SBB = 4'h3, OP_CMP = 4'h4,
		OP_AND  = 4'h5, OP_OR  = 4'h6, OP_XOR = 4'h7, OP_STR = 4'h8, OP_ADDR = 4'h9
	} op_t;

	typedef enum logic [1:0] {SRC_REG = 2'h0, SRC_IMM = 2'h1, SRC_MEM = 2'h2} src_t;

	// Command word: imm[31:16] ilen[15:13] src[12:11] srcr[10:8] dst[7:5] byte[4] op[3:0].
	typedef struct packed {
		logic [15:0] imm;
		logic [2:0]  ilen;
		logic [1:0]  src;
		logic [2:0]  srcr;
		logic [2:0]  dst;
		logic        byte_m;
		logic [3:0]  op;
	} cmd_t;

	typedef struct packed {
		logic [15:0] val;
		logic        cf;
		logic        af;
		logic        of;
	} alu_res_t;
endpackage
`default_nettype wire

// *** verilog/cpu_status_flags_regs.sv ***
// Register set and status-word flag logic of a 16-bit core, reached over AXI4-Lite.
// Functional notes
// - Carry flag, bit 0, set on carry out of or borrow into the top bit.
// - Parity flag, bit 2, set when the low result byte has even ones.
// - Auxiliary carry, bit 4, set on carry or borrow across the low nibble.
// - Zero flag, bit 6, set when the result is zero.
// - Sign flag, bit 7, copies the result's top bit.
// - Single-step flag, bit 8, traps after the next command and is cleared.
// - Maskable requests are vectored only while interrupt enable, bit 9, is set.
// - Direction flag, bit 10, makes string steps decrement, else increment.
// - Overflow flag, bit 11, set when a signed result does not fit.
// - Status word is 16 bits: six result flags, three control flags.
// - Fourteen architectural registers: general, segment, pointer and status.
// - Eight 16-bit general registers serve as arithmetic and logical operands.
// - The first four general registers are also usable as two byte halves.
// - Four 16-bit segment registers select code, stack and data segments.
// - General registers act as base and index for operand offsets.
// - Instruction pointer holds the offset of the next instruction.
// - Operands come from a register, the immediate field or memory.
// - Physical address is segment shifted left four plus offset, 20 bits.
`timescale 1ns/10ps
`default_nettype none
module cpu_status_flags_regs
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        maskable_irq,
	output logic             irq_vector,
	output logic             single_step_trap,
	output logic [19:0]      phys_addr
);
	logic [15:0]                  gen_ff [8];
	logic [15:0]                  nxt_gen [8];
	logic [15:0]                  seg_ff [4];
	logic [15:0]                  nxt_seg [4];
	logic [15:0]                  ip_ff, nxt_ip;
	logic [15:0]                  psw_ff, nxt_psw;
	logic [15:0]                  mem_ff;
	logic [19:0]                  phys_ff;
	cpu_regs_pkg::cmd_t           cmd_ff;
	logic                         exec_ff;
	logic                         step_trap_ff, irq_vec_ff;
	logic                         irq_meta_ff, irq_sync_ff;
	logic [7:0]                   waddr_ff;
	logic [31:0]                  wdata_ff;
	logic [3:0]                   wstrb_ff;
	logic                         aw_got_ff, w_got_ff;
	logic                         awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
	logic [1:0]                   bresp_ff, rresp_ff;
	logic [31:0]                  rdata_ff;
	logic                         aw_take, w_take, ar_take, do_wr;
	logic                         nxt_aw_got, nxt_w_got, nxt_bvalid, nxt_rvalid;
	logic [7:0]                   wa, ra;
	logic [31:0]                  wmerge, rd_word;
	logic                         wr_ok, rd_ok, wr_gen, wr_seg, wr_ip, wr_psw, wr_cmd, wr_mem;
	logic [15:0]                  dst_word, src_word, idx_word, op_a, op_b, src_val;
	logic [15:0]                  wb_word, ea_off, str_delta;
	logic [2:0]                   wsel;
	logic                         flag_op, wb_dst, is_str, is_addr;
	cpu_regs_pkg::alu_res_t       alu_r;

	function automatic logic [31:0] lane_mask(input logic [3:0] strb);
		lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
	endfunction

	// Byte codes 0..3 pick low halves of the first four words, 4..7 their high halves.
	function automatic logic [15:0] pick(input logic [15:0] w, input logic hi, input logic bm);
		pick = bm ? {8'h00, hi ? w[15:8] : w[7:0]} : w;
	endfunction

	function automatic logic top_bit(input logic [15:0] x, input logic bm);
		top_bit = bm ? x[7] : x[15];
	endfunction

	function automatic cpu_regs_pkg::alu_res_t alu(input logic [3:0] op, input logic [15:0] a,
		input logic [15:0] b, input logic cin, input logic bm);
		logic [16:0] s;
		logic [4:0]  n;
		logic        sub;
		logic        c;
		alu = '0;
		sub = (op == cpu_regs_pkg::OP_SUB) || (op == cpu_regs_pkg::OP_SBB)
			|| (op == cpu_regs_pkg::OP_CMP);
		c   = ((op == cpu_regs_pkg::OP_ADC) || (op == cpu_regs_pkg::OP_SBB)) & cin;
		s   = sub ? {1'b0, a} - {1'b0, b} - {16'h0000, c} : {1'b0, a} + {1'b0, b} + {16'h0000, c};
		n   = sub ? {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, c}
			: {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, c};
		if (op == cpu_regs_pkg::OP_AND)
			alu.val = a & b;
		else if (op == cpu_regs_pkg::OP_OR)
			alu.val = a | b;
		else if (op == cpu_regs_pkg::OP_XOR)
			alu.val = a ^ b;
		else
		begin
			alu.val = bm ? {8'h00, s[7:0]} : s[15:0];
			// Operands are zero-extended, so a byte borrow also shows in bit 8.
			alu.cf  = bm ? s[8] : s[16];
			alu.af  = n[4];
			alu.of  = (top_bit(a, bm) ~^ (top_bit(b, bm) ^ sub))
				& (top_bit(alu.val, bm) ^ top_bit(a, bm));
		end
	endfunction

	// Write channel: address and data are taken independently, the write lands once both are in.
	assign aw_take    = s_axi_awvalid & awready_ff;
	assign w_take     = s_axi_wvalid & wready_ff;
	assign do_wr      = aw_got_ff & w_got_ff & ~bvalid_ff;
	assign nxt_aw_got = (aw_got_ff | aw_take) & ~do_wr;
	assign nxt_w_got  = (w_got_ff | w_take) & ~do_wr;
	assign nxt_bvalid = do_wr | (bvalid_ff & ~s_axi_bready);
	assign ar_take    = s_axi_arvalid & arready_ff;
	assign nxt_rvalid = ar_take | (rvalid_ff & ~s_axi_rready);

	assign wa     = {waddr_ff[7:2], 2'b00};
	assign ra     = {s_axi_araddr[7:2], 2'b00};
	assign wr_ok  = wa <= cpu_regs_pkg::PHYS_ADDR;
	assign rd_ok  = ra <= cpu_regs_pkg::PHYS_ADDR;
	assign wr_gen = do_wr && (wa < cpu_regs_pkg::SEG_BASE);
	assign wr_seg = do_wr && (wa >= cpu_regs_pkg::SEG_BASE) && (wa < cpu_regs_pkg::IP_ADDR);
	assign wr_ip  = do_wr && (wa == cpu_regs_pkg::IP_ADDR);
	assign wr_psw = do_wr && (wa == cpu_regs_pkg::PSW_ADDR);
	assign wr_cmd = do_wr && (wa == cpu_regs_pkg::CMD_ADDR);
	assign wr_mem = do_wr && (wa == cpu_regs_pkg::MEM_ADDR);

	assign rd_word = (ra < cpu_regs_pkg::SEG_BASE) ? {16'h0000, gen_ff[ra[4:2]]} :
		(ra < cpu_regs_pkg::IP_ADDR) ? {16'h0000, seg_ff[ra[3:2]]} :
		(ra == cpu_regs_pkg::IP_ADDR) ? {16'h0000, ip_ff} :
		(ra == cpu_regs_pkg::PSW_ADDR) ? {16'h0000, psw_ff} :
		(ra == cpu_regs_pkg::CMD_ADDR) ? cmd_ff :
		(ra == cpu_regs_pkg::MEM_ADDR) ? {16'h0000, mem_ff} :
		(ra == cpu_regs_pkg::PHYS_ADDR) ? {12'h000, phys_ff} : 32'h0000_0000;

	// Command word merged with the current one so narrow writes keep the other lanes.
	assign wmerge = (wa == cpu_regs_pkg::CMD_ADDR)
		? ((cmd_ff & ~lane_mask(wstrb_ff)) | (wdata_ff & lane_mask(wstrb_ff)))
		: (wdata_ff & lane_mask(wstrb_ff));

	// Operand fetch for the command latched on the previous cycle.
	assign wsel     = cmd_ff.byte_m ? {1'b0, cmd_ff.dst[1:0]} : cmd_ff.dst;
	assign dst_word = gen_ff[wsel];
	assign src_word = gen_ff[cmd_ff.byte_m ? {1'b0, cmd_ff.srcr[1:0]} : cmd_ff.srcr];
	assign idx_word = gen_ff[cmd_ff.dst];
	assign op_a     = pick(dst_word, cmd_ff.dst[2], cmd_ff.byte_m);
	assign src_val  = (cmd_ff.src == cpu_regs_pkg::SRC_IMM) ? cmd_ff.imm :
		(cmd_ff.src == cpu_regs_pkg::SRC_MEM) ? mem_ff :
		pick(src_word, cmd_ff.srcr[2], cmd_ff.byte_m);
	assign op_b     = cmd_ff.byte_m ? {8'h00, src_val[7:0]} : src_val;
	assign alu_r    = alu(cmd_ff.op, op_a, op_b, psw_ff[cpu_regs_pkg::CARRY_POS], cmd_ff.byte_m);
	assign flag_op  = ~cmd_ff.op[3];
	assign wb_dst   = flag_op && (cmd_ff.op != cpu_regs_pkg::OP_CMP);
	assign is_str   = cmd_ff.op == cpu_regs_pkg::OP_STR;
	assign is_addr  = cmd_ff.op == cpu_regs_pkg::OP_ADDR;
	assign wb_word  = !cmd_ff.byte_m ? alu_r.val :
		cmd_ff.dst[2] ? {alu_r.val[7:0], dst_word[7:0]} : {dst_word[15:8], alu_r.val[7:0]};
	// Base plus index plus displacement, wrapping within the 64K segment.
	assign ea_off    = idx_word + gen_ff[cmd_ff.srcr] + cmd_ff.imm;
	assign str_delta = cmd_ff.byte_m ? cpu_regs_pkg::BYTE_STEP : cpu_regs_pkg::WORD_STEP;

	always_comb
	begin
		for (int i = 0; i < 8; i++)
			nxt_gen[i] = gen_ff[i];
		for (int i = 0; i < 4; i++)
			nxt_seg[i] = seg_ff[i];
		if (wr_gen)
			nxt_gen[wa[4:2]] = wmerge[15:0];
		if (wr_seg)
			nxt_seg[wa[3:2]] = wmerge[15:0];
		if (exec_ff && wb_dst)
			nxt_gen[wsel] = wb_word;
		if (exec_ff && is_str)
			nxt_gen[cmd_ff.dst] = psw_ff[cpu_regs_pkg::DIR_POS] ? idx_word - str_delta
				: idx_word + str_delta;
	end

	always_comb
	begin
		nxt_ip = wr_ip ? wmerge[15:0] : ip_ff;
		if (exec_ff)
			nxt_ip = ip_ff + {13'h0000, cmd_ff.ilen};
	end

	// A software write to the status word loses to a flag update in the same cycle.
	always_comb
	begin
		nxt_psw = psw_ff;
		if (wr_psw)
			nxt_psw = (wmerge[15:0] & cpu_regs_pkg::PSW_LIVE) | cpu_regs_pkg::PSW_RSVD_VAL;
		if (exec_ff && flag_op)
		begin
			nxt_psw[cpu_regs_pkg::CARRY_POS]  = alu_r.cf;
			nxt_psw[cpu_regs_pkg::PARITY_POS] = ~^alu_r.val[7:0];
			nxt_psw[cpu_regs_pkg::AUX_POS]    = alu_r.af;
			nxt_psw[cpu_regs_pkg::ZERO_POS]   = alu_r.val == 16'h0000;
			nxt_psw[cpu_regs_pkg::SIGN_POS]   = top_bit(alu_r.val, cmd_ff.byte_m);
			nxt_psw[cpu_regs_pkg::OVFL_POS]   = alu_r.of;
		end
		if (exec_ff && psw_ff[cpu_regs_pkg::STEP_POS])
			nxt_psw[cpu_regs_pkg::STEP_POS] = 1'b0;
	end

	// Fourteen architectural registers: eight general, four segment, pointer and status.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int i = 0; i < 8; i++)
				gen_ff[i] <= cpu_regs_pkg::GEN_RESET;
			for (int i = 0; i < 4; i++)
				seg_ff[i] <= cpu_regs_pkg::SEG_RESET;
			ip_ff  <= cpu_regs_pkg::IP_RESET;
			psw_ff <= cpu_regs_pkg::PSW_RESET;
		end
		else
		begin
			gen_ff <= nxt_gen;
			seg_ff <= nxt_seg;
			ip_ff  <= nxt_ip;
			psw_ff <= nxt_psw;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cmd_ff       <= '0;
			mem_ff       <= 16'h0000;
			exec_ff      <= 1'b0;
			phys_ff      <= 20'h00000;
			step_trap_ff <= 1'b0;
		end
		else
		begin
			cmd_ff       <= wr_cmd ? wmerge : cmd_ff;
			mem_ff       <= wr_mem ? wmerge[15:0] : mem_ff;
			exec_ff      <= wr_cmd;
			phys_ff      <= (exec_ff && is_addr)
				? ({4'h0, seg_ff[cmd_ff.src]} << cpu_regs_pkg::SEG_SHIFT) + {4'h0, ea_off}
				: phys_ff;
			step_trap_ff <= exec_ff && psw_ff[cpu_regs_pkg::STEP_POS];
		end
	end

	// The request pin is asynchronous; the first stage feeds only the second.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			irq_meta_ff <= 1'b0;
			irq_sync_ff <= 1'b0;
			irq_vec_ff  <= 1'b0;
		end
		else
		begin
			irq_meta_ff <= maskable_irq;
			irq_sync_ff <= irq_meta_ff;
			irq_vec_ff  <= irq_sync_ff && psw_ff[cpu_regs_pkg::INTR_POS];
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got_ff  <= 1'b0;
			w_got_ff   <= 1'b0;
			awready_ff <= 1'b0;
			wready_ff  <= 1'b0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= cpu_regs_pkg::RESP_OKAY;
			waddr_ff   <= 8'h00;
			wdata_ff   <= 32'h0000_0000;
			wstrb_ff   <= 4'h0;
		end
		else
		begin
			aw_got_ff  <= nxt_aw_got;
			w_got_ff   <= nxt_w_got;
			awready_ff <= ~nxt_aw_got & ~nxt_bvalid;
			wready_ff  <= ~nxt_w_got & ~nxt_bvalid;
			bvalid_ff  <= nxt_bvalid;
			bresp_ff   <= do_wr ? (wr_ok ? cpu_regs_pkg::RESP_OKAY : cpu_regs_pkg::RESP_SLVERR)
				: bresp_ff;
			waddr_ff   <= aw_take ? s_axi_awaddr : waddr_ff;
			wdata_ff   <= w_take ? s_axi_wdata : wdata_ff;
			wstrb_ff   <= w_take ? s_axi_wstrb : wstrb_ff;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= 32'h0000_0000;
			rresp_ff   <= cpu_regs_pkg::RESP_OKAY;
		end
		else
		begin
			arready_ff <= ~nxt_rvalid;
			rvalid_ff  <= nxt_rvalid;
			rdata_ff   <= ar_take ? rd_word : rdata_ff;
			rresp_ff   <= ar_take ? (rd_ok ? cpu_regs_pkg::RESP_OKAY : cpu_regs_pkg::RESP_SLVERR)
				: rresp_ff;
		end
	end

	assign s_axi_awready    = awready_ff;
	assign s_axi_wready     = wready_ff;
	assign s_axi_bvalid     = bvalid_ff;
	assign s_axi_bresp      = bresp_ff;
	assign s_axi_arready    = arready_ff;
	assign s_axi_rvalid     = rvalid_ff;
	assign s_axi_rdata      = rdata_ff;
	assign s_axi_rresp      = rresp_ff;
	assign irq_vector       = irq_vec_ff;
	assign single_step_trap = step_trap_ff;
	assign phys_addr        = phys_ff;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	AST_CARRY_WORD: assert property (
		exec_ff && cmd_ff.op == cpu_regs_pkg::OP_ADD && !cmd_ff.byte_m
		|=> psw_ff[0] == $past(({1'b0, op_a} + {1'b0, op_b}) >> 16))
		else $error("carry flag wrong after word add");
	AST_PARITY: assert property (
		exec_ff && flag_op |=> psw_ff[2] == ~^$past(alu_r.val[7:0]))
		else $error("parity flag wrong");
	AST_AUX: assert property (
		exec_ff && cmd_ff.op == cpu_regs_pkg::OP_ADD
		|=> psw_ff[4] == $past(((op_a & 16'h000f) + (op_b & 16'h000f)) > 16'h000f))
		else $error("auxiliary carry wrong after add");
	AST_ZERO: assert property (
		exec_ff && wb_dst && !cmd_ff.byte_m |=> psw_ff[6] == (gen_ff[$past(cmd_ff.dst)] == 16'h0000))
		else $error("zero flag disagrees with stored result");
	AST_SIGN: assert property (
		exec_ff && wb_dst && !cmd_ff.byte_m |=> psw_ff[7] == gen_ff[$past(cmd_ff.dst)][15])
		else $error("sign flag disagrees with stored result");
	AST_STEP_TRAP: assert property (
		exec_ff && psw_ff[8] |=> single_step_trap && !psw_ff[8] ##1 !single_step_trap)
		else $error("single-step trap not a one-cycle pulse with flag cleared");
	AST_IRQ_GATE: assert property (
		irq_vector |-> $past(psw_ff[9]) && $past(irq_sync_ff))
		else $error("request vectored while interrupts disabled");
	AST_STR_DIR: assert property (
		exec_ff && is_str && !cmd_ff.byte_m
		|=> gen_ff[$past(cmd_ff.dst)] == ($past(psw_ff[10]) ? $past(idx_word) - 16'h0002
			: $past(idx_word) + 16'h0002))
		else $error("string index stepped the wrong way");
	AST_RSVD: assert property (
		(psw_ff & ~cpu_regs_pkg::PSW_LIVE) == cpu_regs_pkg::PSW_RSVD_VAL)
		else $error("reserved status bits moved");
	AST_IP_ADV: assert property (
		exec_ff |=> ip_ff == $past(ip_ff) + {13'h0000, $past(cmd_ff.ilen)})
		else $error("instruction pointer not advanced by length");
endmodule
`default_nettype wire

// *** verif/cpu_status_flags_regs_test.sv ***
// Self-checking testbench of the register set and status-word flag logic.
`timescale 1ns/10ps
`default_nettype none
module cpu_status_flags_regs_test;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	logic        maskable_irq = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic        irq_vector, single_step_trap;
	logic [19:0] phys_addr;
	logic [15:0] gen [8];
	logic [15:0] seg [4];
	logic [15:0] ip, psw, mem;
	logic [19:0] phys;
	logic [31:0] seed = 32'h3b6c;
	int          errors, checks_done, exp_traps, traps, cycles;

	cpu_status_flags_regs i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .maskable_irq, .irq_vector,
		.single_step_trap, .phys_addr);

	always #5 aclk = ~aclk;

	task automatic conclude;
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// The hang limit is far above the few thousand cycles the sequence needs.
	always @(posedge aclk)
	begin
		cycles++;
		if (single_step_trap === 1'b1)
			traps++;
		if (cycles == 20000)
		begin
			errors++;
			conclude();
		end
	end

	function automatic logic [31:0] nxt_rand(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		cmp({30'h0, s_axi_bresp}, {30'h0, er});
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		cmp(s_axi_rdata, exp);
		cmp({30'h0, s_axi_rresp}, {30'h0, er});
	endtask

	// Byte codes 0-3 are low halves and 4-7 high halves of the first four registers.
	function automatic int getr(input logic [2:0] c, input logic bm);
		return bm ? (c[2] ? gen[c[1:0]][15:8] : gen[c[1:0]][7:0]) : gen[c];
	endfunction

	task automatic exec(input cpu_regs_pkg::cmd_t cm);
		int   w, a, b, r, s;
		w = cm.byte_m ? 8 : 16;
		a = getr(cm.dst, cm.byte_m);
		b = (cm.src == 2'h1) ? int'(cm.imm) : (cm.src == 2'h2) ? int'(mem) : getr(cm.srcr, cm.byte_m);
		if (cm.byte_m)
			b = b & 'hff;
		if (cm.op <= 4'h7)
		begin
			s = (cm.op == 4'h1 || cm.op == 4'h3) ? int'(psw[0]) : 0;
			if (cm.op <= 4'h1)
				r = a + b + s;
			else if (cm.op <= 4'h4)
				r = a - b - s;
			else if (cm.op == 4'h5)
				r = a & b;
			else if (cm.op == 4'h6)
				r = a | b;
			else
				r = a ^ b;
			s = (cm.op <= 4'h1) ? ((a ^ r) & (b ^ r)) : ((a ^ b) & (a ^ r));
			psw[0] = (cm.op <= 4'h4) && r[w];
			psw[2] = ~^r[7:0];
			psw[4] = (cm.op <= 4'h4) && ((a ^ b ^ r) & 16) != 0;
			psw[6] = (r & ((1 << w) - 1)) == 0;
			psw[7] = r[w - 1];
			psw[11] = (cm.op <= 4'h4) && s[w - 1];
			if (cm.op != 4'h4 && cm.byte_m)
			begin
				if (cm.dst[2])
					gen[cm.dst[1:0]][15:8] = r[7:0];
				else
					gen[cm.dst[1:0]][7:0] = r[7:0];
			end
			else if (cm.op != 4'h4)
				gen[cm.dst] = r[15:0];
		end
		else if (cm.op == 4'h8)
		begin
			s = cm.byte_m ? 1 : 2;
			gen[cm.dst] = psw[10] ? gen[cm.dst] - 16'(s) : gen[cm.dst] + 16'(s);
		end
		else if (cm.op == 4'h9)
			phys = {seg[cm.src], 4'h0} + {4'h0, 16'(gen[cm.dst] + gen[cm.srcr] + cm.imm)};
		ip = ip + 16'(cm.ilen);
		if (psw[8])
		begin
			exp_traps++;
			psw[8] = 1'b0;
		end
	endtask

	initial
	begin
		cpu_regs_pkg::cmd_t cm;
		logic [2:0]         idx;
		ip = 16'h0;
		psw = 16'h0;
		mem = 16'h0;
		phys = 20'h0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i <= 16; i++)
			rd(8'(4 * i), 32'h0, cpu_regs_pkg::RESP_OKAY);
		rd(8'h44, 32'h0, cpu_regs_pkg::RESP_SLVERR);
		wr(8'h44, 32'h1234, cpu_regs_pkg::RESP_SLVERR);
		wr(cpu_regs_pkg::PHYS_ADDR, 32'hffffffff, cpu_regs_pkg::RESP_OKAY);
		rd(cpu_regs_pkg::PHYS_ADDR, 32'h0, cpu_regs_pkg::RESP_OKAY);
		for (int i = 0; i < 12; i++)
		begin
			seed = nxt_rand(seed);
			wr(8'(4 * i), seed, cpu_regs_pkg::RESP_OKAY);
			if (i < 8)
				gen[i] = seed[15:0];
			else
				seg[i - 8] = seed[15:0];
			rd(8'(4 * i), {16'h0, seed[15:0]}, cpu_regs_pkg::RESP_OKAY);
		end
		// Only lane 0 strobed: the unstrobed upper byte of a 16-bit register is written as 0.
		s_axi_wstrb <= 4'h1;
		wr(cpu_regs_pkg::GEN_BASE, 32'h0000abcd, cpu_regs_pkg::RESP_OKAY);
		s_axi_wstrb <= 4'hf;
		gen[0] = 16'h00cd;
		rd(cpu_regs_pkg::GEN_BASE, {16'h0, gen[0]}, cpu_regs_pkg::RESP_OKAY);
		wr(cpu_regs_pkg::PSW_ADDR, 32'hfffffeff, cpu_regs_pkg::RESP_OKAY);
		psw = 16'hfeff & cpu_regs_pkg::PSW_LIVE;
		rd(cpu_regs_pkg::PSW_ADDR, {16'h0, psw}, cpu_regs_pkg::RESP_OKAY);
		@(posedge aclk);
		maskable_irq <= 1'b1;
		repeat (5) @(posedge aclk);
		cmp({31'h0, irq_vector}, 32'h1);
		wr(cpu_regs_pkg::PSW_ADDR, 32'h0, cpu_regs_pkg::RESP_OKAY);
		psw = 16'h0;
		repeat (5) @(posedge aclk);
		cmp({31'h0, irq_vector}, 32'h0);
		maskable_irq <= 1'b0;
		for (int n = 0; n < 96; n++)
		begin
			seed = nxt_rand(seed);
			if (n % 6 == 0)
			begin
				wr(cpu_regs_pkg::PSW_ADDR, seed, cpu_regs_pkg::RESP_OKAY);
				psw = seed[15:0] & cpu_regs_pkg::PSW_LIVE;
				seed = nxt_rand(seed);
				wr(cpu_regs_pkg::MEM_ADDR, seed, cpu_regs_pkg::RESP_OKAY);
				mem = seed[15:0];
			end
			wr(8'(4 * seed[2:0]), {seed[15:0], seed[31:16]}, cpu_regs_pkg::RESP_OKAY);
			gen[seed[2:0]] = seed[31:16];
			seed = nxt_rand(seed);
			cm = seed;
			cm.op = 4'(n % 12);
			if (cm.op != 4'h9 && cm.src == 2'h3)
				cm.src = 2'h0;
			wr(cpu_regs_pkg::CMD_ADDR, cm, cpu_regs_pkg::RESP_OKAY);
			exec(cm);
			idx = cm.byte_m ? {1'b0, cm.dst[1:0]} : cm.dst;
			rd(8'(4 * idx), {16'h0, gen[idx]}, cpu_regs_pkg::RESP_OKAY);
			rd(cpu_regs_pkg::PSW_ADDR, {16'h0, psw}, cpu_regs_pkg::RESP_OKAY);
			rd(cpu_regs_pkg::IP_ADDR, {16'h0, ip}, cpu_regs_pkg::RESP_OKAY);
			cmp({12'h0, phys_addr}, {12'h0, phys});
			cmp(traps, exp_traps);
		end
		rd(cpu_regs_pkg::PHYS_ADDR, {12'h0, phys}, cpu_regs_pkg::RESP_OKAY);
		// A second reset in mid-run: the status word, first general register and physical address must read back their reset values.
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rd(cpu_regs_pkg::PSW_ADDR, {16'h0, cpu_regs_pkg::PSW_RESET}, cpu_regs_pkg::RESP_OKAY);
		rd(cpu_regs_pkg::GEN_BASE, {16'h0, cpu_regs_pkg::GEN_RESET}, cpu_regs_pkg::RESP_OKAY);
		rd(cpu_regs_pkg::PHYS_ADDR, 32'h0, cpu_regs_pkg::RESP_OKAY);
		conclude();
	end
endmodule
`default_nettype wire
